// ### bench/tws_host_model.sv
// host-side two-wire master model: drives the serial clock and the data wire
`timescale 1ns/10ps
module tws_host_model (
   // two-wire pins
   output logic sclk,
   output logic sdaLine,
   input wire logic sdaOe,
   input wire logic sdaOut
);
   // bit period 250 ns, slower than mclk over 22
   localparam time HALF = 125ns;
   logic hostSda;

   // pulled-up wire, low while either party pulls it
   assign sdaLine = ((sdaOe && !sdaOut) || !hostSda) ? 1'b0 : 1'b1;

   // idle: both lines high, clock stands still between frames
   initial begin
      sclk = 1'b1;
      hostSda = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // start, also as repeated start without a stop
   task automatic start();
      #60 hostSda = 1'b1;
      #65 sclk = 1'b1;
      #HALF hostSda = 1'b0;
      #HALF sclk = 1'b0;
   endtask

   task automatic stop();
      #60 hostSda = 1'b0;
      #65 sclk = 1'b1;
      #HALF hostSda = 1'b1;
      #HALF;
   endtask

   // MSB first, data moved only while the clock is low
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #60 hostSda = b[i];
         #65 sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      #60 hostSda = 1'b1;
      #65 sclk = 1'b1;
      ack = ~sdaLine;
      #HALF sclk = 1'b0;
   endtask

   // ack asks for another byte, nack ends the read
   task automatic recvByte(input logic nack, output logic [7:0] b);
      #60 hostSda = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #65 sclk = 1'b1;
         b[i] = sdaLine;
         #HALF sclk = 1'b0;
         #60;
      end
      hostSda = nack;
      #65 sclk = 1'b1;
      #HALF sclk = 1'b0;
   endtask
endmodule // tws_host_model

// ### bench/tws_target_bench.sv
// self-checking bench for the two-wire register target
`timescale 1ns/10ps
module tws_target_bench;
   logic mclk, srst, sclk, sdaLine, sdaOut, sdaOe, sel, wrStb, rdReq;
   logic oePrev, sclPrev, a;
   logic [15:0] regAddr;
   logic [7:0] wrData, rdData, b;
   logic [7:0] mem [0:255];
   logic [7:0] ids [4];
   int miscompares = 0;
   int n_checks = 0;

   tws_target uut (.mclk(mclk), .srst(srst), .sclk(sclk), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .targetAddressSelect(sel),
      .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb), .rdReq(rdReq),
      .rdData(rdData));
   tws_host_model host (.sclk(sclk), .sdaLine(sdaLine), .sdaOe(sdaOe),
      .sdaOut(sdaOut));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // register file behind the target; read data latched per request
   always @(posedge mclk) begin
      if (wrStb === 1'b1) begin
         mem[regAddr[7:0]] <= wrData;
      end
      if (rdReq === 1'b1) begin
         rdData <= mem[regAddr[7:0]];
      end
   end

   // a target that moved the wire with clock high would fake a start or
   // stop
   always @(posedge mclk) begin
      if (srst === 1'b0 && sclk && sclPrev && sdaOe !== oePrev) begin
         $display("mismatch sdaOe expected %b seen %b", oePrev, sdaOe);
         miscompares++;
      end
      if (sdaOe === 1'b1 && sdaOut !== 1'b0) begin
         $display("mismatch sdaOut expected 0 seen %b", sdaOut);
         miscompares++;
      end
      oePrev <= sdaOe;
      sclPrev <= sclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic doReset();
      @(posedge mclk) #1 srst = 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk("sdaOe", 16'h0000, {15'h0000, sdaOe});
      chk("regAddr", tws_pkg::TWS_ADDR_RST, regAddr);
      chk("strobes", 16'h0000, {14'h0000, wrStb, rdReq});
      srst = 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   // write-direction select then the 16-bit register address
   task automatic setAddr(input logic [7:0] id, input logic [15:0] ra);
      host.start();
      host.sendByte(id, a);
      chk("ack id", 16'h0001, {15'h0000, a});
      host.sendByte(ra[15:8], a);
      chk("ack hi", 16'h0001, {15'h0000, a});
      host.sendByte(ra[7:0], a);
      chk("ack lo", 16'h0001, {15'h0000, a});
   endtask

   task automatic sendData(input logic [7:0] d);
      host.sendByte(d, a);
      chk("ack data", 16'h0001, {15'h0000, a});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // 16-bit unit written, ended by stop
   task automatic t_write();
      setAddr(tws_pkg::TWS_ID_LO_WR, 16'h0012);
      sendData(8'hA5);
      sendData(8'h3C);
      host.stop();
      chk("mem 12", 16'h00A5, {8'h00, mem[8'h12]});
      chk("mem 13", 16'h003C, {8'h00, mem[8'h13]});
      chk("addr", 16'h0014, regAddr);
   endtask

   // dummy write, restart, sequential read
   task automatic t_randRead();
      setAddr(tws_pkg::TWS_ID_LO_WR, 16'h0012);
      host.start();
      host.sendByte(tws_pkg::TWS_ID_LO_RD, a);
      chk("ack rd", 16'h0001, {15'h0000, a});
      host.recvByte(1'b0, b);
      chk("rd 12", 16'h00A5, {8'h00, b});
      host.recvByte(1'b1, b);
      chk("rd 13", 16'h003C, {8'h00, b});
      host.stop();
      chk("oe off", 16'h0000, {15'h0000, sdaOe});
      chk("addr", 16'h0014, regAddr);
   endtask

   // two independent reads from the current address
   task automatic t_curRead();
      mem[8'h14] = 8'h5A;
      mem[8'h15] = 8'hC3;
      for (int i = 0; i < 2; i++) begin
         host.start();
         host.sendByte(tws_pkg::TWS_ID_LO_RD, a);
         host.recvByte(1'b1, b);
         host.stop();
         chk("cur rd", i ? 16'h00C3 : 16'h005A, {8'h00, b});
      end
   endtask

   // each select level: foreign ids ignored, own ids answered
   task automatic t_select();
      for (int s = 0; s < 2; s++) begin
         @(posedge mclk) #1 sel = s[0];
         repeat (4) @(posedge mclk);
         for (int k = 0; k < 2; k++) begin
            host.start();
            host.sendByte(ids[2 * (1 - s) + k], a);
            host.stop();
            chk("nack foreign", 16'h0000, {15'h0000, a});
         end
         mem[8'h32] = 8'h77;
         setAddr(ids[2 * s], 16'h0030);
         sendData(8'h40 | s[7:0]);
         sendData(8'h50 | s[7:0]);
         host.start();
         host.sendByte(ids[2 * s + 1], a);
         chk("ack own rd", 16'h0001, {15'h0000, a});
         host.recvByte(1'b1, b);
         host.stop();
         chk("rd 32", 16'h0077, {8'h00, b});
         chk("mem 31", 16'h0050 | s[15:0], {8'h00, mem[8'h31]});
      end
   endtask

   initial begin
      srst = 1'b1;
      sel = 1'b0;
      rdData = 8'h00;
      ids = '{tws_pkg::TWS_ID_LO_WR, tws_pkg::TWS_ID_LO_RD,
         tws_pkg::TWS_ID_HI_WR, tws_pkg::TWS_ID_HI_RD};
      doReset();
      t_write();
      t_randRead();
      t_curRead();
      doReset();
      t_select();
      conclude();
   end

   // the whole sequence needs about 83 us of serial traffic
   initial begin
      #400us;
      miscompares++;
      $display("mismatch watchdog expected end seen timeout");
      conclude();
   end
endmodule // tws_target_bench

// ### src/tws_bit_if.sv
// carrier between the serial-clock capture and the mclk protocol engine
`timescale 1ns/10ps
interface tws_bit_if;
   logic linkRst;
   logic sdaLine;
   logic bitTgl;
   logic bitVal;

   modport capture (
      input linkRst,
      input sdaLine,
      output bitTgl,
      output bitVal
   );

   modport engine (
      output linkRst,
      output sdaLine,
      input bitTgl,
      input bitVal
   );
endinterface

// ### src/tws_link_capture.sv
// serial-clock domain: samples one data bit per rising serial clock edge
`timescale 1ns/10ps
module tws_link_capture (
   // link clock from the host
   input wire logic sclk,
   // towards the engine
   tws_bit_if.capture lnk
);

   tws_pkg::tws_link_t r;
   tws_pkg::tws_link_t n;

   // bit value is held until the next rising edge, long after the toggle
   // has crossed, so the engine reads it without its own synchroniser
   always_comb begin
      n.bitTgl = ~r.bitTgl;
      n.bitVal = lnk.sdaLine;
   end

   // the serial clock is stopped outside frames, so reset cannot wait
   // for an edge here
   always_ff @(posedge sclk or posedge lnk.linkRst) begin
      if (lnk.linkRst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lnk.bitTgl = r.bitTgl;
   assign lnk.bitVal = r.bitVal;

endmodule // tws_link_capture

// ### src/tws_pkg.sv
// shared constants and types of the two-wire register target
package tws_pkg;

   // address bytes answered, by target_address_select level
   localparam logic [7:0] TWS_ID_LO_WR = 8'h90;
   localparam logic [7:0] TWS_ID_LO_RD = 8'h91;
   localparam logic [7:0] TWS_ID_HI_WR = 8'hBA;
   localparam logic [7:0] TWS_ID_HI_RD = 8'hBB;

   // bit slots within one byte period
   localparam logic [3:0] TWS_LAST_BIT = 4'h7;
   localparam logic [3:0] TWS_ACK_SLOT = 4'h8;

   // host must keep its serial clock at or below mclk / this ratio
   localparam int TWS_CLK_RATIO = 22;

   localparam logic [15:0] TWS_ADDR_RST = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_DEVADDR = 3'h1,
      ST_REGHI   = 3'h3,
      ST_REGLO   = 3'h2,
      ST_WDATA   = 3'h6,
      ST_RDATA   = 3'h7
   } tws_state_t;

   typedef struct packed {
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic [1:0] selSync;
      logic [1:0] tglSync;
      logic sclPrev;
      logic sdaPrev;
      logic tglPrev;
      tws_state_t st;
      logic [3:0] bitCnt;
      logic [7:0] shReg;
      logic rw;
      logic ackPend;
      logic ackOn;
      logic sdaOe;
      logic sdaOut;
      logic [15:0] regAddr;
      logic [7:0] wrData;
      logic wrStb;
      logic rdReq;
      logic linkRst;
   } tws_regs_t;

   localparam tws_regs_t TWS_REGS_RST = '{
      sclSync: 2'h3, sdaSync: 2'h3, selSync: 2'h0, tglSync: 2'h0,
      sclPrev: 1'b1, sdaPrev: 1'b1, tglPrev: 1'b0, st: ST_IDLE,
      bitCnt: 4'h0, shReg: 8'h00, rw: 1'b0, ackPend: 1'b0,
      ackOn: 1'b0, sdaOe: 1'b0, sdaOut: 1'b0, regAddr: TWS_ADDR_RST,
      wrData: 8'h00, wrStb: 1'b0, rdReq: 1'b0, linkRst: 1'b1};

   typedef struct packed {
      logic bitTgl;
      logic bitVal;
   } tws_link_t;

endpackage

// ### src/tws_target.sv
// two-wire register target: protocol engine on mclk
//
// Behaviour
// - target only; never drives clock, start, stop
// - register address always sixteen bits
// - both lines high means bus idle
// - data falls, clock high: start
// - data rises, clock high: stop
// - start without stop is repeated start
// - bytes MSB first, then acknowledge bit
// - data changes only while clock low
// - first byte: seven address bits, direction
// - select low answers 90h write, 91h read
// - select high answers BAh write, BBh read
// - receiver pulls data low to acknowledge
// - acknowledge address byte only on match
// - write: address high, low, then data
// - address advances after each written byte
// - read advances address after each byte
// - host no-acknowledge ends read, device releases
// - read alone uses current internal address
`timescale 1ns/10ps
module tws_target (
   // system
   input wire logic mclk,
   input wire logic srst,
   // two-wire pins
   input wire logic sclk,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic targetAddressSelect,
   // register side
   output logic [15:0] regAddr,
   output logic [7:0] wrData,
   output logic wrStb,
   output logic rdReq,
   input wire logic [7:0] rdData
);

   ////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] devId(input logic sel);
      devId = sel ? tws_pkg::TWS_ID_HI_WR[7:1]
                  : tws_pkg::TWS_ID_LO_WR[7:1];
   endfunction

   tws_bit_if lnk ();

   tws_link_capture u_cap (
      .sclk(sclk),
      .lnk(lnk.capture)
   );

   tws_pkg::tws_regs_t r;
   tws_pkg::tws_regs_t n;
   logic rise;
   logic fall;
   logic startDet;
   logic stopDet;
   logic [7:0] newByte;

   assign lnk.linkRst = r.linkRst;
   assign lnk.sdaLine = sdaIn;

   ////////////////////////////////////////////////////////////////////
   // line events, all from second synchroniser stages onward
   assign rise = r.tglSync[1] != r.tglPrev;
   assign fall = r.sclPrev & ~r.sclSync[1];
   assign startDet = r.sclSync[1] & r.sclPrev & r.sdaPrev
                   & ~r.sdaSync[1];
   assign stopDet = r.sclSync[1] & r.sclPrev & ~r.sdaPrev
                  & r.sdaSync[1];
   assign newByte = {r.shReg[6:0], lnk.bitVal};

   always_comb begin
      n = r;
      n.wrStb = 1'b0;
      n.rdReq = 1'b0;
      n.sdaOut = 1'b0; // open drain: only ever pulls low
      n.linkRst = srst;
      n.sclSync = {r.sclSync[0], sclk};
      n.sdaSync = {r.sdaSync[0], sdaIn};
      n.selSync = {r.selSync[0], targetAddressSelect};
      n.tglSync = {r.tglSync[0], lnk.bitTgl};
      n.sclPrev = r.sclSync[1];
      n.sdaPrev = r.sdaSync[1];
      n.tglPrev = r.tglSync[1];
      if (startDet) begin
         n.st = tws_pkg::ST_DEVADDR;
         n.bitCnt = 4'h0;
         n.ackPend = 1'b0;
         n.ackOn = 1'b0;
         n.sdaOe = 1'b0;
      end else if (stopDet) begin
         n.st = tws_pkg::ST_IDLE;
         n.bitCnt = 4'h0;
         n.ackPend = 1'b0;
         n.ackOn = 1'b0;
         n.sdaOe = 1'b0;
      end else begin
         // rising serial clock: the bit is sampled in the link domain
         if (rise && r.st != tws_pkg::ST_IDLE) begin
            if (r.bitCnt != tws_pkg::TWS_ACK_SLOT) begin
               // while sending, the shift register only moves on falls
               if (r.st != tws_pkg::ST_RDATA) begin
                  n.shReg = newByte;
               end
               n.bitCnt = r.bitCnt + 4'h1;
               if (r.bitCnt == tws_pkg::TWS_LAST_BIT) begin
                  unique case (r.st)
                     tws_pkg::ST_DEVADDR: begin
                        if (newByte[7:1] == devId(r.selSync[1])) begin
                           n.ackPend = 1'b1;
                           n.rw = newByte[0];
                           n.rdReq = newByte[0];
                        end else begin
                           n.st = tws_pkg::ST_IDLE;
                        end
                     end
                     tws_pkg::ST_REGHI: begin
                        n.regAddr[15:8] = newByte;
                        n.ackPend = 1'b1;
                     end
                     tws_pkg::ST_REGLO: begin
                        n.regAddr[7:0] = newByte;
                        n.ackPend = 1'b1;
                     end
                     tws_pkg::ST_WDATA: begin
                        n.wrData = newByte;
                        n.wrStb = 1'b1;
                        n.ackPend = 1'b1;
                     end
                     tws_pkg::ST_RDATA: begin
                        n.shReg = r.shReg; // shifting out, not in
                     end
                     default: begin
                        n.st = tws_pkg::ST_IDLE;
                     end
                  endcase
               end
            end else begin
               // acknowledge slot
               n.bitCnt = 4'h0;
               unique case (r.st)
                  tws_pkg::ST_DEVADDR: begin
                     n.st = r.rw ? tws_pkg::ST_RDATA : tws_pkg::ST_REGHI;
                  end
                  tws_pkg::ST_REGHI: begin
                     n.st = tws_pkg::ST_REGLO;
                  end
                  tws_pkg::ST_REGLO: begin
                     n.st = tws_pkg::ST_WDATA;
                  end
                  tws_pkg::ST_WDATA: begin
                     n.regAddr = r.regAddr + 16'h0001;
                  end
                  tws_pkg::ST_RDATA: begin
                     n.regAddr = r.regAddr + 16'h0001;
                     if (lnk.bitVal) begin
                        n.st = tws_pkg::ST_IDLE;
                        n.sdaOe = 1'b0;
                     end else begin
                        n.rdReq = 1'b1;
                     end
                  end
                  default: begin
                     n.st = tws_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         // falling serial clock: the only moment the data line moves
         if (fall) begin
            if (r.ackPend) begin
               n.sdaOe = 1'b1;
               n.ackPend = 1'b0;
               n.ackOn = 1'b1;
            end else begin
               n.ackOn = 1'b0;
               n.sdaOe = 1'b0;
               if (r.st == tws_pkg::ST_RDATA) begin
                  if (r.bitCnt == 4'h0) begin
                     n.shReg = rdData;
                     n.sdaOe = ~rdData[7];
                  end else if (r.bitCnt != tws_pkg::TWS_ACK_SLOT) begin
                     n.shReg = {r.shReg[6:0], 1'b0};
                     n.sdaOe = ~r.shReg[6];
                  end
               end
            end
         end
      end
   end

   // the target never touches the clock line and never makes
   // start or stop: it only starts or ends pulling data low while the clock is low
   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= tws_pkg::TWS_REGS_RST;
      end else begin
         r <= n;
      end
   end

   assign sdaOut = r.sdaOut;
   assign sdaOe = r.sdaOe;
   assign regAddr = r.regAddr;
   assign wrData = r.wrData;
   assign wrStb = r.wrStb;
   assign rdReq = r.rdReq;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_byteIn;
      rise && r.bitCnt == tws_pkg::TWS_LAST_BIT
         && r.st inside {tws_pkg::ST_REGHI, tws_pkg::ST_REGLO,
                         tws_pkg::ST_WDATA};
   endsequence

   sequence s_ackFall;
      r.ackPend && fall && !startDet && !stopDet;
   endsequence

   sequence s_hostNack;
      rise && r.st == tws_pkg::ST_RDATA
         && r.bitCnt == tws_pkg::TWS_ACK_SLOT && lnk.bitVal;
   endsequence

   a_start_restarts: assert property (@(posedge mclk) disable iff (srst)
      startDet |=> r.st == tws_pkg::ST_DEVADDR && r.bitCnt == 4'h0
         && !sdaOe)
      else $error("start did not restart the byte engine");

   a_stop_idles: assert property (@(posedge mclk) disable iff (srst)
      stopDet |=> r.st == tws_pkg::ST_IDLE && !sdaOe)
      else $error("stop did not release the bus");

   a_addr_match: assert property (@(posedge mclk) disable iff (srst)
      rise && r.st == tws_pkg::ST_DEVADDR && !startDet && !stopDet
         && r.bitCnt == tws_pkg::TWS_LAST_BIT
         && newByte[7:1] == devId(r.selSync[1])
         |=> r.ackPend ##0 (!fall)[*1] ##[1:1000] sdaOe)
      else $error("matching address byte not acknowledged");

   a_addr_miss: assert property (@(posedge mclk) disable iff (srst)
      rise && r.st == tws_pkg::ST_DEVADDR && !startDet && !stopDet
         && r.bitCnt == tws_pkg::TWS_LAST_BIT
         && newByte[7:1] != devId(r.selSync[1])
         |=> r.st == tws_pkg::ST_IDLE && !r.ackPend)
      else $error("foreign address byte was claimed");

   a_byte_acked: assert property (@(posedge mclk) disable iff (srst)
      s_byteIn and (!startDet && !stopDet) |=> r.ackPend)
      else $error("received byte not armed for acknowledge");

   a_ack_on_fall: assert property (@(posedge mclk) disable iff (srst)
      s_ackFall |=> sdaOe && r.ackOn)
      else $error("acknowledge not driven after clock fall");

   a_drive_clk_low: assert property (@(posedge mclk) disable iff (srst)
      $rose(sdaOe) |-> !r.sclPrev)
      else $error("data line pulled while clock high");

   a_write_advance: assert property (@(posedge mclk) disable iff (srst)
      rise && r.st == tws_pkg::ST_WDATA && !startDet && !stopDet
         && r.bitCnt == tws_pkg::TWS_ACK_SLOT
         |=> regAddr == $past(regAddr) + 16'h0001)
      else $error("write address did not advance");

   a_nack_release: assert property (@(posedge mclk) disable iff (srst)
      s_hostNack and (!startDet && !stopDet)
         |=> !sdaOe && r.st == tws_pkg::ST_IDLE && !rdReq)
      else $error("no-acknowledge did not end the read");

   a_idle_quiet: assert property (@(posedge mclk) disable iff (srst)
      r.st == tws_pkg::ST_IDLE && $past(r.st) == tws_pkg::ST_IDLE
         |-> !sdaOe && !wrStb)
      else $error("activity on an idle bus");

endmodule // tws_target
